// *** chase_pkg.sv ***
// Shared constants, state codes and arithmetic helpers of the timecode follower
package chase_pkg;

    // ----------------------------------------------------------------
    // Timecode units
    // ----------------------------------------------------------------
    localparam int unsigned SUBFRAMES_PER_FRAME = 100;
    localparam int unsigned SUBFRAME_LAST       = 99;
    localparam int unsigned SECONDS_PER_MINUTE  = 60;
    localparam int unsigned MINUTES_PER_HOUR    = 60;
    localparam logic signed [31:0] OFFSET_RESET = 32'sh0;

    // ----------------------------------------------------------------
    // Selectable windows and lengths
    // ----------------------------------------------------------------
    localparam int unsigned WINDOW_SHORT_S    = 1;
    localparam int unsigned WINDOW_LONG_S     = 2;
    localparam int unsigned SKIP_SHORT_FRAMES = 10;
    localparam int unsigned SKIP_LONG_FRAMES  = 30;
    localparam int unsigned LOCK_FRAMES       = 4;
    localparam int unsigned FLASH_FRAMES      = 8;
    localparam logic [3:0]  MASTER_MACHINE    = 4'h1;

    // ----------------------------------------------------------------
    // Offset edit cursor positions
    // ----------------------------------------------------------------
    localparam logic [2:0] FIELD_SUB_UNITS = 3'h0;
    localparam logic [2:0] FIELD_SUB_TENS  = 3'h1;
    localparam logic [2:0] FIELD_FRAMES    = 3'h2;
    localparam logic [2:0] FIELD_SECONDS   = 3'h3;
    localparam logic [2:0] FIELD_MINUTES   = 3'h4;
    localparam logic [2:0] FIELD_HOURS     = 3'h5;
    localparam logic [2:0] FIELD_CAPTURE   = 3'h6;

    // ----------------------------------------------------------------
    // Follow states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_DECK     = 3'b001,
        ST_READY    = 3'b010,
        ST_MISMATCH = 3'b011,
        ST_CHASE    = 3'b100,
        ST_LOCKED   = 3'b101,
        ST_RESYNC   = 3'b110,
        ST_FREE     = 3'b111
    } follow_e;

    // Weight of one step of an offset field, in subframes
    function automatic logic signed [31:0] field_weight(input logic [2:0] field,
                                                       input logic [5:0] fps);
        int unsigned sec;
        sec = SUBFRAMES_PER_FRAME * fps;
        case (field)
            FIELD_SUB_UNITS: field_weight = 32'sh1;
            FIELD_SUB_TENS:  field_weight = 32'sha;
            FIELD_FRAMES:    field_weight = 32'(SUBFRAMES_PER_FRAME);
            FIELD_SECONDS:   field_weight = 32'(sec);
            FIELD_MINUTES:   field_weight = 32'(sec * SECONDS_PER_MINUTE);
            FIELD_HOURS:     field_weight = 32'(sec * SECONDS_PER_MINUTE * MINUTES_PER_HOUR);
            default:         field_weight = 32'sh0;
        endcase
    endfunction : field_weight

    // Magnitude of a signed subframe difference
    function automatic logic [31:0] magnitude(input logic signed [31:0] v);
        magnitude = v[31] ? 32'(-v) : 32'(v);
    endfunction : magnitude

endpackage : chase_pkg

// *** offset_editor.sv ***
// Signed timecode offset store with field editing and on-the-fly capture
module offset_editor (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [2:0]         field,
    input  wire logic               key_up,
    input  wire logic               key_down,
    input  wire logic               capture_ok,
    input  wire logic [5:0]         fps,
    input  wire logic signed [31:0] captured,
    output logic signed [31:0]      offset,
    output logic                    nonzero
);

    // ----------------------------------------------------------------
    // Offset storage
    // ----------------------------------------------------------------
    logic signed [31:0] step;

    assign step = chase_pkg::field_weight(field, fps);

    // Held as one signed subframe total, so a subframe step past 99 carries
    // into the frames field with no extra logic
    always_ff @(posedge clk)
    begin
        if (rst)
            offset <= chase_pkg::OFFSET_RESET;
        else if (key_up && key_down)
            offset <= chase_pkg::OFFSET_RESET;
        else if (field == chase_pkg::FIELD_CAPTURE)
        begin
            if ((key_up || key_down) && capture_ok)
                offset <= captured;
        end
        else if (key_up)
            offset <= offset + step;
        else if (key_down)
            offset <= offset - step;
    end

    // All zeros cancels offsetting
    assign nonzero = (offset != chase_pkg::OFFSET_RESET);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_SUB_CARRY: assert property (
        (field == chase_pkg::FIELD_SUB_UNITS && key_up && !key_down
         && offset == 32'sh63) |=> offset == 32'sh64)
        else $error("Subframe step past 99 did not carry");

    AST_BOTH_ZERO: assert property (
        (key_up && key_down) |=> (offset == 32'sh0 && !nonzero))
        else $error("Up and down together did not clear offset");

    AST_CAPTURE: assert property (
        (field == chase_pkg::FIELD_CAPTURE && key_up && !key_down)
        |=> offset == ($past(capture_ok) ? $past(captured) : $past(offset)))
        else $error("Capture stored wrong offset");

    COV_CAPTURE: cover property (
        field == chase_pkg::FIELD_CAPTURE && key_down && capture_ok);

endmodule : offset_editor

// *** tc_master.sv ***
// Behavioural external timecode master that feeds frame ticks and code time
module tc_master (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic        bad,
    output logic             tick,
    output logic             valid,
    output logic             err,
    output logic [31:0]      tc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    initial {tick, valid, err, tc} = '0;
    // ------------------------------------------------------------
    // Frame every ten cycles; code time stands still while stopped
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cnt   <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
        tick  <= run && cnt == 4'h9;
        valid <= run; // Code drops with the transport
        err   <= run && bad;
        if (run && cnt == 4'h9)
            tc <= tc + 32'h64; // One frame is 100 subframes
    end
endmodule : tc_master

// *** testbench.sv ***
// Self-checking bench of the timecode follower
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, fkey = 0, tb = 1, up = 0, dn = 0, cap = 0, run = 0, slave = 0;
    logic rch = 0, wl = 0, skp = 0, ci = 0, kd = 0;
    logic bad = 0, sub = 0, su, mu;
    logic [3:0] mach = 4'h1;
    logic [5:0] erate = 6'h19;
    logic [2:0] fld = 3'h0;
    logic [31:0] trk = 32'h0, tc, v;
    logic tick, valid, err, fl, dk, rw, ep, lk, lamp;
    logic [31:0] ad, rd, off;
    logic signed [31:0] eo = 0, w[6] = '{1, 10, 100, 2500, 150000, 9000000};
    logic [31:0] q[$];
    int fails = 0, total_checks = 0, i;
    always #2 clk = ~clk;
    // Slave time moves in the same step as the master, less the offset, so it can settle
    wire [31:0] fol = slave ? tc - eo : trk;
    tc_master ext (.clk(clk), .run(run), .bad(bad), .tick(tick), .valid(valid),
        .err(err), .tc(tc));
    timecode_chase_synchronizer #(.LOCK_FRAMES(2), .FLASH_FRAMES(2)) uut (.REF_CLK(clk),
        .SYS_RST(rst), .FRAME_TICK(tick), .FOLLOW_KEY(fkey), .MACHINE_NUMBER(mach),
        .TIME_BASE_CODE(tb), .EXT_CODE_VALID(valid), .EXT_CODE_ERROR(err),
        .EXT_FRAME_RATE(erate), .FRAME_RATE(6'h19), .EXT_TIME(tc),
        .INT_TRACK_TIME(sub ? ~fol : fol),
        .INT_SUBCODE_TIME(sub ? fol : ~fol), .INT_FROM_SUBCODE(sub), .RECHASE_MODE(rch),
        .WINDOW_LONG(wl), .ERROR_SKIP_LENGTH(skp), .CLOCK_INTERNAL(ci), .PARK_TEST(1'b0),
        .EDIT_FIELD(fld), .KEY_UP(up), .KEY_DOWN(dn), .AUTO_CAPTURE_OK(cap),
        .FOLLOW_LAMP(fl), .DECK_SYNC_MODE(dk), .RATE_WARNING(rw),
        .EXTERNAL_CODE_PRESENT_LAMP(ep), .LOCKED(lk), .SPEED_UP(su), .SLOW_DOWN(),
        .PLAY_MUTE(mu), .PARK_WIND_FWD(), .PARK_WIND_REV(), .PARK_TIME(), .ABS_DIFF(ad),
        .REL_DIFF(rd), .OFFSET_LAMP(lamp), .CODE_OFFSET_SETTING(off));
    // ------------------------------------------------------------
    // Watcher: one edit answer per key press, oldest note first
    // ------------------------------------------------------------
    always @(posedge clk) kd <= up | dn;
    always @(negedge clk)
    begin
        if (kd && q.size() > 0)
        begin
            v = q.pop_front();
            `CHK("offset", v, off)
            `CHK("offset_lamp", v != 0, lamp)
        end
    end
    task automatic key(input logic [2:0] f, input logic u, input logic d);
        @(posedge clk);
        fld <= f; up <= u; dn <= d;
        if (u && d) eo = 0;
        else if (f == 3'h6) begin if (cap) eo = tc - trk; end
        else eo += u ? w[f] : -w[f];
        q.push_back(eo);
        @(posedge clk);
        up <= 0; dn <= 0;
    endtask : key
    task automatic reset_and_press(input logic [3:0] m, input logic b, input logic [5:0] r);
        @(posedge clk);
        rst <= 1; mach <= m; tb <= b; erate <= r; eo = 0;
        repeat (5) @(posedge clk);
        rst <= 0;
        repeat (40) @(posedge clk); // Let code presence settle over a few frames
        fkey <= 1;
        @(posedge clk);
        fkey <= 0;
        for (i = 0; i < 300 && lk !== 1'b1; i++) @(negedge clk);
    endtask : reset_and_press
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin #100000; fails++; complete_run; end
    initial
    begin
        void'($urandom(32'h1b24b806));
        {rch, wl, skp, ci} = 4'($urandom);
        repeat (5) @(posedge clk);
        rst <= 0;
        repeat (12) key(3'($urandom % 6), i[0], !i[0]); // i stays 0: down steps first
        repeat (6) key(3'($urandom % 6), 1'b1, 1'b0);
        key(3'h0, 1'b1, 1'b1);
        repeat (9) key(3'h1, 1'b1, 1'b0);
        repeat (10) key(3'h0, 1'b1, 1'b0);
        trk <= $urandom % 1000000;
        key(3'h6, 1'b1, 1'b0); // Refused while capture unavailable
        cap <= 1;
        key(3'h6, 1'b0, 1'b1);
        repeat (3) @(negedge clk);
        `CHK("abs_diff", tc - trk, ad)
        `CHK("rel_diff", 32'h0, rd)
        run <= 1; slave <= 1;
        reset_and_press(4'h1, 1'b1, 6'h19);
        `CHK("code_lamp", 1'b1, ep)
        `CHK("locked", 1'b1, lk)
        `CHK("follow_lamp", 1'b1, fl)
        // Push the slave far outside the window: rechase steers and mutes, free ignores it
        @(posedge clk) eo <= 32'h493e0;
        repeat (3) @(negedge clk);
        `CHK("speed_up", rch, su)
        `CHK("mute", rch & !ci, mu)
        `CHK("lock_drop", !rch, lk)
        // A short burst of bad frames is bridged, a long one drops the code
        @(posedge clk) bad <= 1;
        repeat (50) @(negedge clk);
        `CHK("bridge", 1'b1, ep)
        repeat (10 * (skp ? chase_pkg::SKIP_LONG_FRAMES : chase_pkg::SKIP_SHORT_FRAMES))
            @(negedge clk);
        `CHK("code_drop", 1'b0, ep)
        @(posedge clk) bad <= 0;
        reset_and_press(4'h1, 1'b1, 6'h1e);
        `CHK("rate_warn", 1'b1, rw)
        `CHK("no_lock", 1'b0, lk)
        reset_and_press(4'h3, 1'b0, 6'h19);
        `CHK("deck_mode", 1'b1, dk)
        sub <= 1; // Only the subcode time follows the master now
        reset_and_press(4'h3, 1'b1, 6'h19);
        `CHK("code_lock", 1'b1, lk)
        `CHK("deck_off", 1'b0, dk)
        complete_run;
    end
endmodule : testbench

// *** timecode_chase_synchronizer.sv ***
// Transport follower that slaves the recorder to external timecode
//
// Contract
// - Machine one follows external code on key
// - Other machines pick deck sync or code
// - Flash when ready, steady once locked
// - Rate mismatch warns and blocks following
// - Signed offset kept down to subframes
// - Offset lamp lit while offset nonzero
// - Subframe step past 99 carries frames
// - Up and down together clear offset
// - Capture stores incoming minus internal difference
// - Relative difference equals absolute minus offset
// - Park test winds, then stores pre-roll
// - Rechase corrects speed; free ignores code
// - Mute during correction unless internal clock
// - Rechase only beyond 1 or 2 s
// - Bridge code errors of 10 or 30
// - Internal code from track or subcode
module timecode_chase_synchronizer #(
    parameter int unsigned LOCK_FRAMES  = chase_pkg::LOCK_FRAMES,
    parameter int unsigned FLASH_FRAMES = chase_pkg::FLASH_FRAMES
) (
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        FRAME_TICK,
    input  wire logic        FOLLOW_KEY,
    input  wire logic [3:0]  MACHINE_NUMBER,
    input  wire logic        TIME_BASE_CODE,
    input  wire logic        EXT_CODE_VALID,
    input  wire logic        EXT_CODE_ERROR,
    input  wire logic [5:0]  EXT_FRAME_RATE,
    input  wire logic [5:0]  FRAME_RATE,
    input  wire logic [31:0] EXT_TIME,
    input  wire logic [31:0] INT_TRACK_TIME,
    input  wire logic [31:0] INT_SUBCODE_TIME,
    input  wire logic        INT_FROM_SUBCODE,
    input  wire logic        RECHASE_MODE,
    input  wire logic        WINDOW_LONG,
    input  wire logic        ERROR_SKIP_LENGTH,
    input  wire logic        CLOCK_INTERNAL,
    input  wire logic        PARK_TEST,
    input  wire logic [2:0]  EDIT_FIELD,
    input  wire logic        KEY_UP,
    input  wire logic        KEY_DOWN,
    input  wire logic        AUTO_CAPTURE_OK,
    output logic             FOLLOW_LAMP,
    output logic             DECK_SYNC_MODE,
    output logic             RATE_WARNING,
    output logic             EXTERNAL_CODE_PRESENT_LAMP,
    output logic             LOCKED,
    output logic             SPEED_UP,
    output logic             SLOW_DOWN,
    output logic             PLAY_MUTE,
    output logic             PARK_WIND_FWD,
    output logic             PARK_WIND_REV,
    output logic [15:0]      PARK_TIME,
    output logic [31:0]      ABS_DIFF,
    output logic [31:0]      REL_DIFF,
    output logic             OFFSET_LAMP,
    output logic [31:0]      CODE_OFFSET_SETTING
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    chase_pkg::follow_e state;
    chase_pkg::follow_e next_state;
    logic signed [31:0] internal_time;
    logic signed [31:0] raw_diff;
    logic signed [31:0] offset;
    logic signed [31:0] rel_now;
    logic [31:0]        rel_mag;
    logic [31:0]        window;
    logic [5:0]         error_run;
    logic [5:0]         skip_limit;
    logic               code_ok;
    logic               rate_match;
    logic [7:0]         lock_count;
    logic [7:0]         flash_count;
    logic               flash;
    logic               correcting;
    logic               park_test_d;
    logic               park_active;
    logic               master_ran;
    logic [15:0]        park_count;

    // ----------------------------------------------------------------
    // Differences
    // ----------------------------------------------------------------
    // Internal code source chosen per tape mode
    assign internal_time = INT_FROM_SUBCODE ? INT_SUBCODE_TIME : INT_TRACK_TIME;
    assign raw_diff      = $signed(EXT_TIME) - internal_time;
    assign rel_now       = raw_diff - offset;
    assign rel_mag       = chase_pkg::magnitude(rel_now);

    // Both differences registered together so display sees a coherent pair
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            ABS_DIFF <= 32'h0;
            REL_DIFF <= 32'h0;
        end
        else
        begin
            ABS_DIFF <= raw_diff;
            REL_DIFF <= rel_now;
        end
    end

    // Window of one or two seconds, in subframes
    assign window = 32'((WINDOW_LONG ? chase_pkg::WINDOW_LONG_S : chase_pkg::WINDOW_SHORT_S)
                        * FRAME_RATE * chase_pkg::SUBFRAMES_PER_FRAME);

    // ----------------------------------------------------------------
    // Offset store
    // ----------------------------------------------------------------
    offset_editor u_offset (
        .clk        (REF_CLK),
        .rst        (SYS_RST),
        .field      (EDIT_FIELD),
        .key_up     (KEY_UP),
        .key_down   (KEY_DOWN),
        .capture_ok (AUTO_CAPTURE_OK),
        .fps        (FRAME_RATE),
        .captured   (raw_diff),
        .offset     (offset),
        .nonzero    (OFFSET_LAMP)
    );

    assign CODE_OFFSET_SETTING = offset;

    // ----------------------------------------------------------------
    // Incoming code health
    // ----------------------------------------------------------------
    assign skip_limit = ERROR_SKIP_LENGTH ? 6'(chase_pkg::SKIP_LONG_FRAMES)
                                          : 6'(chase_pkg::SKIP_SHORT_FRAMES);
    assign rate_match = (EXT_FRAME_RATE == FRAME_RATE);

    // Bad frames are bridged up to the chosen length; a longer run drops code
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            error_run <= 6'h0;
            code_ok   <= 1'b0;
        end
        else if (FRAME_TICK)
        begin
            if (EXT_CODE_VALID && !EXT_CODE_ERROR)
            begin
                error_run <= 6'h0;
                code_ok   <= 1'b1;
            end
            else if (error_run >= skip_limit)
                code_ok   <= 1'b0;
            else
                error_run <= error_run + 6'h1;
        end
    end

    assign EXTERNAL_CODE_PRESENT_LAMP = code_ok;

    // ----------------------------------------------------------------
    // Follow state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            chase_pkg::ST_IDLE:
                if (FOLLOW_KEY)
                begin
                    if (MACHINE_NUMBER == chase_pkg::MASTER_MACHINE)
                    begin
                        if (code_ok)
                            next_state = chase_pkg::ST_READY;
                    end
                    else if (TIME_BASE_CODE)
                        next_state = chase_pkg::ST_READY;
                    else
                        next_state = chase_pkg::ST_DECK;
                end
            chase_pkg::ST_DECK:
                if (FOLLOW_KEY)
                    next_state = chase_pkg::ST_IDLE;
            chase_pkg::ST_READY:
                if (FOLLOW_KEY)
                    next_state = chase_pkg::ST_IDLE;
                else if (code_ok && !rate_match)
                    next_state = chase_pkg::ST_MISMATCH;
                else if (code_ok)
                    next_state = chase_pkg::ST_CHASE;
            chase_pkg::ST_MISMATCH:
                if (FOLLOW_KEY)
                    next_state = chase_pkg::ST_IDLE;
                else if (rate_match || !code_ok)
                    next_state = chase_pkg::ST_READY;
            chase_pkg::ST_CHASE, chase_pkg::ST_RESYNC:
                if (FOLLOW_KEY)
                    next_state = chase_pkg::ST_IDLE;
                else if (!code_ok || !rate_match)
                    next_state = chase_pkg::ST_READY;
                else if (lock_count >= 8'(LOCK_FRAMES))
                    next_state = RECHASE_MODE ? chase_pkg::ST_LOCKED
                                              : chase_pkg::ST_FREE;
            chase_pkg::ST_LOCKED:
                if (FOLLOW_KEY)
                    next_state = chase_pkg::ST_IDLE;
                else if (!code_ok || !rate_match)
                    next_state = chase_pkg::ST_READY;
                else if (!RECHASE_MODE)
                    next_state = chase_pkg::ST_FREE;
                else if (rel_mag > window)
                    next_state = chase_pkg::ST_RESYNC;
            chase_pkg::ST_FREE:
                if (FOLLOW_KEY)
                    next_state = chase_pkg::ST_IDLE;
            default:
                next_state = chase_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            state <= chase_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // Lock qualification
    // ----------------------------------------------------------------
    assign correcting = (state == chase_pkg::ST_CHASE) || (state == chase_pkg::ST_RESYNC);

    // Counts frames in a row with the slave within one frame of target
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST || !correcting)
            lock_count <= 8'h0;
        else if (FRAME_TICK)
        begin
            if (rel_mag < 32'(chase_pkg::SUBFRAMES_PER_FRAME))
                lock_count <= lock_count + 8'h1;
            else
                lock_count <= 8'h0;
        end
    end

    // ----------------------------------------------------------------
    // Indicators and transport commands
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            flash_count <= 8'h0;
            flash       <= 1'b0;
        end
        else if (FRAME_TICK)
        begin
            if (flash_count >= 8'(FLASH_FRAMES - 1))
            begin
                flash_count <= 8'h0;
                flash       <= !flash;
            end
            else
                flash_count <= flash_count + 8'h1;
        end
    end

    // Flashing until lock, steady afterwards
    assign FOLLOW_LAMP = (state == chase_pkg::ST_LOCKED) || (state == chase_pkg::ST_FREE)
                       || (state == chase_pkg::ST_RESYNC)
                       || (flash && (state == chase_pkg::ST_READY
                                     || state == chase_pkg::ST_MISMATCH
                                     || state == chase_pkg::ST_CHASE));
    assign DECK_SYNC_MODE = (state == chase_pkg::ST_DECK);
    assign RATE_WARNING   = (state == chase_pkg::ST_MISMATCH);
    assign LOCKED         = (state == chase_pkg::ST_LOCKED) || (state == chase_pkg::ST_FREE);

    // Steering only while chasing or resyncing; locked rechase resumes it beyond the window, free mode never does
    assign SPEED_UP  = correcting && !park_active && (rel_now > 32'sh0);
    assign SLOW_DOWN = correcting && !park_active && (rel_now < 32'sh0);
    assign PLAY_MUTE = correcting && !CLOCK_INTERNAL;

    // ----------------------------------------------------------------
    // Park pre-roll measurement
    // ----------------------------------------------------------------
    // Test only arms while following is enabled
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            park_test_d <= 1'b0;
            park_active <= 1'b0;
            master_ran  <= 1'b0;
            park_count  <= 16'h0;
            PARK_TIME   <= 16'h0;
        end
        else
        begin
            park_test_d <= PARK_TEST;
            if (PARK_TEST && !park_test_d)
            begin
                park_active <= (state != chase_pkg::ST_IDLE)
                             && (state != chase_pkg::ST_DECK);
                master_ran  <= 1'b0;
                park_count  <= 16'h0;
            end
            else if (!PARK_TEST && park_test_d)
            begin
                park_active <= 1'b0;
                if (park_active && master_ran)
                    PARK_TIME <= park_count;
            end
            else if (park_active && EXT_CODE_VALID && FRAME_TICK)
            begin
                master_ran <= 1'b1;
                park_count <= park_count + 16'h1;
            end
        end
    end

    // Wind toward zero relative difference before the master rolls
    assign PARK_WIND_FWD = park_active && !master_ran && (rel_now > 32'sh0);
    assign PARK_WIND_REV = park_active && !master_ran && (rel_now < 32'sh0);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    AST_MASTER_ENTRY: assert property (
        (state == chase_pkg::ST_IDLE && FOLLOW_KEY && code_ok
         && MACHINE_NUMBER == 4'h1) |=> state == chase_pkg::ST_READY)
        else $error("Machine one did not enter follow ready");

    AST_DECK_SELECT: assert property (
        (state == chase_pkg::ST_IDLE && FOLLOW_KEY && MACHINE_NUMBER != 4'h1
         && !TIME_BASE_CODE) |=> DECK_SYNC_MODE)
        else $error("Subcode time base did not select deck sync");

    AST_LAMP_STEADY: assert property (
        (state == chase_pkg::ST_LOCKED) |-> FOLLOW_LAMP)
        else $error("Follow lamp not steady when locked");

    AST_RATE_BLOCK: assert property (
        RATE_WARNING |-> (!SPEED_UP && !SLOW_DOWN && !LOCKED))
        else $error("Followed despite rate mismatch");

    AST_OFFSET_LAMP: assert property (
        OFFSET_LAMP == (CODE_OFFSET_SETTING != 32'h0))
        else $error("Offset lamp disagrees with offset");

    AST_REL_DIFF: assert property (
        ##1 (REL_DIFF == 32'(ABS_DIFF - $past(CODE_OFFSET_SETTING))))
        else $error("Relative difference wrong");

    AST_FREE_HOLD: assert property (
        (state == chase_pkg::ST_FREE && !FOLLOW_KEY) |=> state == chase_pkg::ST_FREE)
        else $error("Free mode reacted to incoming code");

    AST_MUTE: assert property (
        (state == chase_pkg::ST_RESYNC && !CLOCK_INTERNAL) |-> PLAY_MUTE)
        else $error("Output not muted while resyncing");

    AST_WINDOW: assert property (
        (state == chase_pkg::ST_LOCKED && rel_mag <= window && code_ok
         && rate_match && RECHASE_MODE && !FOLLOW_KEY)
        |=> state == chase_pkg::ST_LOCKED)
        else $error("Rechase started inside window");

    AST_SKIP: assert property (
        (code_ok && FRAME_TICK && error_run == 6'h0) |=> code_ok)
        else $error("Single bad frame dropped the code");

    COV_LOCK:   cover property (state == chase_pkg::ST_CHASE ##1 state == chase_pkg::ST_LOCKED);
    COV_RESYNC: cover property (state == chase_pkg::ST_LOCKED ##1 state == chase_pkg::ST_RESYNC);
    COV_PARK:   cover property (park_active && master_ran ##1 !park_active);
    COV_WARN:   cover property (RATE_WARNING);

endmodule : timecode_chase_synchronizer
